//--- src/flash_guard_pkg.sv
// constants and carriers shared by the flash store write/erase guard
`default_nettype none
package flash_guard_pkg;
  // -------------------------------------------------------------
  // special register map
  // -------------------------------------------------------------
  localparam logic [7:0] CONTROL_OFFSET = 8'h8f;
  localparam logic [7:0] KEY_OFFSET = 8'hb7;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam int STORE_WRITE_ENABLE_BIT = 0;
  localparam int PAGE_ERASE_ENABLE_BIT = 1;
  // bit of the reset source register that shows a flash error reset
  localparam int FLASH_ERROR_FLAG_BIT = 6;
  // -------------------------------------------------------------
  // key sequence and page geometry
  // -------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST = 8'ha5;
  localparam logic [7:0] KEY_SECOND = 8'hf1;
  localparam int PAGE_SHIFT = 9;
  localparam logic [7:0] LOCK_ERASED = 8'hff;
  localparam logic [1:0] CODE_LOCKED = 2'h0;
  localparam logic [1:0] CODE_FIRST = 2'h1;
  localparam logic [1:0] CODE_OPEN = 2'h2;
  localparam logic [1:0] CODE_DEAD = 2'h3;
  // -------------------------------------------------------------
  // state types
  // -------------------------------------------------------------
  typedef enum logic [3:0] {
    KEY_LOCKED = 4'h1,
    KEY_HALF = 4'h2,
    KEY_OPEN = 4'h4,
    KEY_DEAD = 4'h8
  } key_state_t;
  typedef enum logic [2:0] {
    OP_IDLE = 3'h1,
    OP_BUSY = 3'h2,
    OP_WIPE = 3'h4
  } op_state_t;
  // command to the flash array macro
  typedef struct packed {
    logic prog;
    logic erase;
    logic [15:0] addr;
    logic [7:0] data;
  } fl_cmd_t;
endpackage
`default_nettype wire

//--- src/flash_store_write_erase_guard.sv
// flash store write/erase guard: key lock, page security, command issue
// -------------------------------------------------------------
// -------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module flash_store_write_erase_guard #(
  parameter int ADDR_W = 16,
  parameter int NUM_PAGES = 32,
  parameter logic [15:0] LOCK_ADDR = 16'h3dff
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic xwr_in,
  input wire logic [15:0] xaddr_in,
  input wire logic [7:0] xdata_in,
  input wire logic exec_locked_in,
  output logic xram_wr_out,
  input wire logic dbg_wr_in,
  input wire logic dbg_erase_in,
  input wire logic dbg_dev_erase_in,
  input wire logic [15:0] dbg_addr_in,
  input wire logic [7:0] dbg_data_in,
  input wire logic [7:0] lock_byte_in,
  output flash_guard_pkg::fl_cmd_t fl_cmd_out,
  input wire logic fl_done_in,
  output logic cpu_stall_out,
  output logic err_reset_out,
  output logic flash_error_reset_flag_out
);
  // -------------------------------------------------------------
  // checks and declarations
  // -------------------------------------------------------------
  if (ADDR_W != 16 || NUM_PAGES < 1 || NUM_PAGES > 128 || int'(LOCK_ADDR[15:9]) >= NUM_PAGES)
  begin : geometry_check
    $error("flash guard: unsupported geometry");
  end
  localparam logic [6:0] LOCK_PAGE = LOCK_ADDR[15:9];
  localparam logic [6:0] LAST_PAGE = 7'(NUM_PAGES - 1);

  flash_guard_pkg::key_state_t key_st;
  flash_guard_pkg::op_state_t op_st;
  logic page_erase_enable;
  logic store_write_enable;
  logic [7:0] lock_cur;
  logic rst_d;
  logic err_pend;
  logic [6:0] wipe_pg;
  logic key_wr;
  logic fw_go;
  logic fw_bad;
  logic dbg_go;
  logic dbg_bad;

  // -------------------------------------------------------------
  // decoding helpers
  // -------------------------------------------------------------
  function automatic logic page_locked(input logic [6:0] pg, input logic [7:0] lk);
    logic [7:0] n;
    n = ~lk;
    page_locked = ({1'b0, pg} < n) || (pg == LOCK_PAGE && n != 8'h00);
  endfunction

  function automatic logic [1:0] key_code(input flash_guard_pkg::key_state_t s);
    case (s)
      flash_guard_pkg::KEY_LOCKED: key_code = flash_guard_pkg::CODE_LOCKED;
      flash_guard_pkg::KEY_HALF: key_code = flash_guard_pkg::CODE_FIRST;
      flash_guard_pkg::KEY_OPEN: key_code = flash_guard_pkg::CODE_OPEN;
      default: key_code = flash_guard_pkg::CODE_DEAD;
    endcase
  endfunction

  // lock byte already programmed: checked against the live array value
  function automatic logic lock_hit(input logic [15:0] a, input logic er, input logic [7:0] live);
    lock_hit = live != flash_guard_pkg::LOCK_ERASED && (er ? a[15:9] == LOCK_PAGE : a == LOCK_ADDR);
  endfunction

  assign key_wr = sfr_wr_in && sfr_addr_in == flash_guard_pkg::KEY_OFFSET;
  assign fw_go = xwr_in && store_write_enable && op_st == flash_guard_pkg::OP_IDLE;
  assign fw_bad = (page_locked(xaddr_in[15:9], lock_cur) && !exec_locked_in)
    || lock_hit(xaddr_in, page_erase_enable, lock_byte_in)
    || (page_erase_enable && exec_locked_in && xaddr_in[15:9] == LOCK_PAGE);
  assign dbg_go = (dbg_wr_in || dbg_erase_in) && op_st == flash_guard_pkg::OP_IDLE && !fw_go;
  assign dbg_bad = page_locked(dbg_addr_in[15:9], lock_cur) || lock_hit(dbg_addr_in, dbg_erase_in, lock_byte_in);

  // -------------------------------------------------------------
  // program store control register
  // -------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      store_write_enable <= flash_guard_pkg::CONTROL_RESET[flash_guard_pkg::STORE_WRITE_ENABLE_BIT];
      page_erase_enable <= flash_guard_pkg::CONTROL_RESET[flash_guard_pkg::PAGE_ERASE_ENABLE_BIT];
    end
    else if (sfr_wr_in && sfr_addr_in == flash_guard_pkg::CONTROL_OFFSET)
    begin
      // upper bits have no storage at all
      store_write_enable <= sfr_wdata_in[flash_guard_pkg::STORE_WRITE_ENABLE_BIT];
      page_erase_enable <= sfr_wdata_in[flash_guard_pkg::PAGE_ERASE_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      sfr_rdata_out <= 8'h00;
    else if (sfr_rd_in && sfr_addr_in == flash_guard_pkg::CONTROL_OFFSET)
      sfr_rdata_out <= {6'h00, page_erase_enable, store_write_enable};
    else if (sfr_rd_in && sfr_addr_in == flash_guard_pkg::KEY_OFFSET)
      sfr_rdata_out <= {6'h00, key_code(key_st)};
    else
      sfr_rdata_out <= 8'h00;
  end

  // -------------------------------------------------------------
  // key sequence lock
  // -------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      key_st <= flash_guard_pkg::KEY_LOCKED;
    else
    begin
      case (key_st)
        flash_guard_pkg::KEY_LOCKED:
        begin
          if (fw_go)
            key_st <= flash_guard_pkg::KEY_DEAD;
          else if (key_wr)
            key_st <= sfr_wdata_in == flash_guard_pkg::KEY_FIRST ? flash_guard_pkg::KEY_HALF
              : flash_guard_pkg::KEY_DEAD;
        end
        flash_guard_pkg::KEY_HALF:
        begin
          if (fw_go)
            key_st <= flash_guard_pkg::KEY_DEAD;
          else if (key_wr)
            key_st <= sfr_wdata_in == flash_guard_pkg::KEY_SECOND ? flash_guard_pkg::KEY_OPEN
              : flash_guard_pkg::KEY_DEAD;
        end
        flash_guard_pkg::KEY_OPEN:
        begin
          // a key write while open is a misuse and disables until reset
          if (key_wr)
            key_st <= flash_guard_pkg::KEY_DEAD;
          else if (op_st == flash_guard_pkg::OP_BUSY && fl_done_in)
            key_st <= flash_guard_pkg::KEY_LOCKED;
        end
        default: key_st <= flash_guard_pkg::KEY_DEAD;
      endcase
    end
  end

  // -------------------------------------------------------------
  // security lock capture and error reset
  // -------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    rst_d <= sys_rst_in;
    if (sys_rst_in)
      lock_cur <= 8'h00;
    else if (rst_d)
      lock_cur <= lock_byte_in;
  end

  // the flag survives the reset it causes; any other reset clears it
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      err_pend <= 1'b0;
      err_reset_out <= 1'b0;
      if (!rst_d)
        flash_error_reset_flag_out <= err_pend;
    end
    else
    begin
      err_reset_out <= 1'b0;
      if (fw_go && key_st == flash_guard_pkg::KEY_OPEN && fw_bad)
      begin
        err_pend <= 1'b1;
        err_reset_out <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------
  // flash command issue
  // -------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      op_st <= flash_guard_pkg::OP_IDLE;
      fl_cmd_out <= '0;
      wipe_pg <= 7'h00;
      xram_wr_out <= 1'b0;
    end
    else
    begin
      xram_wr_out <= xwr_in && !store_write_enable;
      case (op_st)
        flash_guard_pkg::OP_IDLE:
        begin
          if (fw_go && key_st == flash_guard_pkg::KEY_OPEN && !fw_bad && !err_pend)
          begin
            op_st <= flash_guard_pkg::OP_BUSY;
            fl_cmd_out.prog <= !page_erase_enable;
            fl_cmd_out.erase <= page_erase_enable;
            fl_cmd_out.addr <= xaddr_in;
            fl_cmd_out.data <= xdata_in;
          end
          else if (dbg_dev_erase_in)
          begin
            op_st <= flash_guard_pkg::OP_WIPE;
            wipe_pg <= 7'h00;
            fl_cmd_out.erase <= 1'b1;
            fl_cmd_out.addr <= 16'h0000;
          end
          else if (dbg_go && !dbg_bad)
          begin
            // forbidden debug requests fall through untouched
            op_st <= flash_guard_pkg::OP_BUSY;
            fl_cmd_out.prog <= !dbg_erase_in;
            fl_cmd_out.erase <= dbg_erase_in;
            fl_cmd_out.addr <= dbg_addr_in;
            fl_cmd_out.data <= dbg_data_in;
          end
        end
        flash_guard_pkg::OP_BUSY:
        begin
          if (fl_done_in)
          begin
            op_st <= flash_guard_pkg::OP_IDLE;
            fl_cmd_out <= '0;
          end
        end
        flash_guard_pkg::OP_WIPE:
        begin
          if (fl_done_in && wipe_pg == LAST_PAGE)
          begin
            op_st <= flash_guard_pkg::OP_IDLE;
            fl_cmd_out <= '0;
          end
          else if (fl_done_in)
          begin
            wipe_pg <= wipe_pg + 7'h01;
            fl_cmd_out.addr <= {wipe_pg + 7'h01, 9'h000};
          end
        end
        default: op_st <= flash_guard_pkg::OP_IDLE;
      endcase
    end
  end

  // the interrupt controller keeps requests while the core is frozen
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      cpu_stall_out <= 1'b0;
    else if (fw_go && key_st == flash_guard_pkg::KEY_OPEN && !fw_bad && !err_pend)
      cpu_stall_out <= 1'b1;
    else if (op_st == flash_guard_pkg::OP_BUSY && fl_done_in)
      cpu_stall_out <= 1'b0;
  end

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  upper_bits_zero_a: assert property (sfr_rdata_out[7:2] == 6'h00)
    else $error("control upper bits not zero");
  key_open_a: assert property (key_st == flash_guard_pkg::KEY_HALF && key_wr && !fw_go
    && sfr_wdata_in == flash_guard_pkg::KEY_SECOND |=> key_st == flash_guard_pkg::KEY_OPEN)
    else $error("second key did not unlock");
  key_wrong_a: assert property (key_st == flash_guard_pkg::KEY_LOCKED && key_wr
    && sfr_wdata_in != flash_guard_pkg::KEY_FIRST |=> key_st == flash_guard_pkg::KEY_DEAD [*3])
    else $error("wrong key did not disable");
  relock_done_a: assert property (op_st == flash_guard_pkg::OP_BUSY && fl_done_in
    && key_st == flash_guard_pkg::KEY_OPEN && !key_wr |=> key_st == flash_guard_pkg::KEY_LOCKED)
    else $error("lock not restored after operation");
  erase_cmd_a: assert property (fw_go && page_erase_enable && key_st == flash_guard_pkg::KEY_OPEN
    && !fw_bad && !err_pend |=> fl_cmd_out.erase && !fl_cmd_out.prog && cpu_stall_out)
    else $error("page erase not issued");
  no_flash_route_a: assert property (xwr_in && !store_write_enable
    && op_st == flash_guard_pkg::OP_IDLE && !dbg_go && !dbg_dev_erase_in |=> xram_wr_out
    && op_st == flash_guard_pkg::OP_IDLE)
    else $error("write reached flash with enable off");
  fw_error_a: assert property (fw_go && key_st == flash_guard_pkg::KEY_OPEN && fw_bad
    |=> err_reset_out && op_st == flash_guard_pkg::OP_IDLE)
    else $error("forbidden access did not reset");
  dbg_quiet_a: assert property (dbg_go && dbg_bad && !dbg_dev_erase_in && !xwr_in
    |=> !err_reset_out && op_st == flash_guard_pkg::OP_IDLE)
    else $error("forbidden debug access acted");
  stall_busy_a: assert property (op_st == flash_guard_pkg::OP_BUSY && !fl_done_in
    && $past(op_st) == flash_guard_pkg::OP_BUSY && $past(cpu_stall_out) |-> cpu_stall_out)
    else $error("cpu released while busy");
  lock_hold_a: assert property (!rst_d |=> $stable(lock_cur))
    else $error("lock changed outside reset");
  wipe_step_a: assert property (op_st == flash_guard_pkg::OP_WIPE && fl_done_in && wipe_pg != LAST_PAGE
    |=> fl_cmd_out.erase && wipe_pg == $past(wipe_pg) + 7'h01)
    else $error("device erase skipped a page");

  unlock_c: cover property (key_st == flash_guard_pkg::KEY_HALF ##1 key_st == flash_guard_pkg::KEY_OPEN);
  erase_c: cover property (op_st == flash_guard_pkg::OP_BUSY && fl_cmd_out.erase ##1 fl_done_in);
  wipe_c: cover property (op_st == flash_guard_pkg::OP_WIPE && wipe_pg == LAST_PAGE && fl_done_in);
  err_c: cover property (err_reset_out);
endmodule
`default_nettype wire

//--- testbench/flash_array_model.sv
// flash array model: answers program and page erase commands after a set delay
`timescale 1ns/1ps
`default_nettype none
module flash_array_model #(
  parameter logic [15:0] LOCK_ADDR = 16'h3dff
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire flash_guard_pkg::fl_cmd_t cmd_in,
  input wire logic [3:0] delay_in,
  output logic done_out,
  output logic [7:0] lock_byte_out
);
  logic [7:0] mem [16384];
  logic [3:0] cnt;
  initial
  begin
    foreach (mem[i]) mem[i] = 8'hff;
    done_out = 1'b0;
    cnt = 4'h0;
  end
  assign lock_byte_out = mem[LOCK_ADDR[13:0]];
  // one idle cycle after each done, so a device erase that keeps the
  // command up with a new page address is served page by page
  always @(posedge clk_in)
  begin
    if (rst_in || done_out || !(cmd_in.prog || cmd_in.erase))
    begin
      done_out <= 1'b0;
      cnt <= 4'h0;
    end
    else if (cnt == delay_in)
    begin
      done_out <= 1'b1;
      // programming can only clear bits, as the real array does
      if (cmd_in.erase)
        for (int i = 0; i < 512; i++) mem[{cmd_in.addr[13:9], i[8:0]}] <= 8'hff;
      else
        mem[cmd_in.addr[13:0]] <= mem[cmd_in.addr[13:0]] & cmd_in.data;
    end
    else
      cnt <= cnt + 4'h1;
  end
endmodule
`default_nettype wire

//--- testbench/flash_store_write_erase_guard_bench.sv
// self-checking bench for the flash store write/erase guard
`timescale 1ns/1ps
`default_nettype none
module flash_store_write_erase_guard_bench;
  localparam logic [15:0] LOCK_ADDR = 16'h3dff;
  localparam logic [7:0] CTL = flash_guard_pkg::CONTROL_OFFSET;
  localparam logic [7:0] KEY = flash_guard_pkg::KEY_OFFSET;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic sfr_wr, sfr_rd, xwr, exec_locked, dbg_wr, dbg_erase, dbg_dev_erase, fl_done;
  logic xram_wr, stall, err_rst, err_flag, we;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, xdata, dbg_data, lock_byte;
  logic [15:0] xaddr, dbg_addr;
  logic [3:0] dly;
  flash_guard_pkg::fl_cmd_t cmd;
  int bad_count = 0;
  int n_checks = 0;
  always #10 clk_in = ~clk_in;
  flash_store_write_erase_guard #(.ADDR_W(16), .NUM_PAGES(32), .LOCK_ADDR(LOCK_ADDR)) u_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .sfr_wr_in(sfr_wr), .sfr_rd_in(sfr_rd),
    .sfr_addr_in(sfr_addr), .sfr_wdata_in(sfr_wdata), .sfr_rdata_out(sfr_rdata), .xwr_in(xwr),
    .xaddr_in(xaddr), .xdata_in(xdata), .exec_locked_in(exec_locked), .xram_wr_out(xram_wr),
    .dbg_wr_in(dbg_wr), .dbg_erase_in(dbg_erase), .dbg_dev_erase_in(dbg_dev_erase),
    .dbg_addr_in(dbg_addr), .dbg_data_in(dbg_data), .lock_byte_in(lock_byte), .fl_cmd_out(cmd),
    .fl_done_in(fl_done), .cpu_stall_out(stall), .err_reset_out(err_rst),
    .flash_error_reset_flag_out(err_flag));
  flash_array_model #(.LOCK_ADDR(LOCK_ADDR)) u_model (.clk_in(clk_in), .rst_in(sys_rst_in),
    .cmd_in(cmd), .delay_in(dly), .done_out(fl_done), .lock_byte_out(lock_byte));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic guard(input logic ok);
    if (!ok)
    begin
      bad_count++;
      $display("ERROR at %0t wait limit got %h expected %h", $time, 1'b0, 1'b1);
      tally_and_finish();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic do_reset();
    sys_rst_in <= 1'b1;
    tick(4);
    sys_rst_in <= 1'b0;
    we = 1'b0;
    tick(2);
  endtask
  task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
    {sfr_addr, sfr_wdata, sfr_wr} <= {a, d, 1'b1};
    tick(1);
    sfr_wr <= 1'b0;
    tick(1);
    if (a == CTL)
      we = d[0];
  endtask
  task automatic sfr_chk(input logic [7:0] a, input logic [7:0] exp);
    {sfr_addr, sfr_rd} <= {a, 1'b1};
    tick(1);
    sfr_rd <= 1'b0;
    #1;
    chk(sfr_rdata, exp);
    tick(1);
  endtask
  task automatic unlock();
    sfr_w(KEY, 8'ha5);
    sfr_chk(KEY, 8'h01);
    sfr_w(KEY, 8'hf1);
    sfr_chk(KEY, 8'h02);
  endtask
  // exp: 0 nothing reaches flash, 1 byte program, 2 page erase, 3 error reset
  task automatic op(input int dbg, input logic [15:0] a, input logic [7:0] d, input int exp);
    int k = 0;
    if (dbg)
      {dbg_addr, dbg_data, dbg_wr, dbg_erase} <= {a, d, exp != 2, exp == 2};
    else
      {xaddr, xdata, xwr} <= {a, d, 1'b1};
    tick(1);
    {xwr, dbg_wr, dbg_erase} <= 3'b000;
    #1;
    chk({cmd.prog, cmd.erase, stall, err_rst, xram_wr},
      {exp == 1, exp == 2, !dbg && exp inside {1, 2}, exp == 3, !dbg && !we});
    if (exp == 1)
      chk({cmd.addr, cmd.data}, {a, d});
    while ((cmd.prog || cmd.erase) && k < 60)
    begin
      tick(1);
      #1;
      k++;
    end
    guard(k < 60);
    chk(stall, 1'b0);
    tick(1);
  endtask
  // pages from 0 counted by the complement of the lock byte, plus its own page
  function automatic logic page_locked(input logic [15:0] a, input logic [7:0] lb);
    logic [7:0] n;
    n = ~lb;
    return ({1'b0, a[15:9]} < n) || (n != 8'h00 && a[15:9] == LOCK_ADDR[15:9]);
  endfunction
  initial
  begin
    int i;
    logic [15:0] a;
    logic [7:0] d;
    logic [7:0] old;
    logic [15:0] addrs [4];
    addrs = '{16'h0100, 16'h0300, 16'h0500, 16'h3d00};
    {sfr_wr, sfr_rd, xwr, exec_locked, dbg_wr, dbg_erase, dbg_dev_erase} = '0;
    {sfr_addr, sfr_wdata, xdata, dbg_data, xaddr, dbg_addr} = '0;
    dly = 4'h1;
    we = 1'b0;
    void'($urandom(32'h95c1));
    do_reset();
    // -------------------------------------------------------------
    // registers and plain writes
    // -------------------------------------------------------------
    sfr_chk(CTL, 8'h00);
    sfr_chk(KEY, 8'h00);
    sfr_w(CTL, 8'hfc);
    sfr_chk(CTL, 8'h00);
    sfr_chk(8'h55, 8'h00);
    op(0, 16'h0400, 8'h3c, 0);
    $display("test registers done");
    // -------------------------------------------------------------
    // random byte programs, then erase of the last page touched
    // -------------------------------------------------------------
    // the bench raises no interrupt and never switches clock source while write enable is set
    sfr_w(CTL, 8'h01);
    for (i = 0; i < 8; i++)
    begin
      a = {5'd2 + 5'($urandom_range(20)), 9'($urandom)};
      d = 8'($urandom);
      dly <= 4'($urandom_range(3));
      old = u_model.mem[a[13:0]];
      unlock();
      op(0, a, d, 1);
      sfr_chk(KEY, 8'h00);
      chk(u_model.mem[a[13:0]], old & d);
    end
    sfr_w(CTL, 8'hff);
    sfr_chk(CTL, 8'h03);
    unlock();
    op(0, a, 8'h00, 2);
    chk(u_model.mem[a[13:0]], 8'hff);
    $display("test program and erase done");
    // -------------------------------------------------------------
    // key misuse disables modification until reset
    // -------------------------------------------------------------
    for (i = 0; i < 3; i++)
    begin
      do_reset();
      sfr_w(CTL, 8'h01);
      if (i < 2)
        sfr_w(KEY, i == 0 ? 8'hf1 : 8'h00);
      if (i < 2)
        sfr_w(KEY, 8'ha5);
      op(0, 16'h0600, 8'h12, 0);
      sfr_chk(KEY, 8'h03);
    end
    $display("test key misuse done");
    // -------------------------------------------------------------
    // page locking by the lock byte
    // -------------------------------------------------------------
    do_reset();
    op(1, LOCK_ADDR, 8'hfd, 1);
    sfr_w(CTL, 8'h01);
    unlock();
    op(0, 16'h0010, 8'h0f, 1);
    unlock();
    op(0, LOCK_ADDR, 8'h00, 3);
    do_reset();
    chk(err_flag, 1'b1);
    do_reset();
    chk(err_flag, 1'b0);
    for (i = 0; i < 4; i++)
    begin
      a = addrs[i];
      op(1, a, 8'h5a, page_locked(a, 8'hfd) ? 0 : 1);
      sfr_w(CTL, 8'h01);
      unlock();
      op(0, a, 8'h5a, page_locked(a, 8'hfd) ? 3 : 1);
      if (page_locked(a, 8'hfd))
        do_reset();
    end
    exec_locked <= 1'b1;
    sfr_w(CTL, 8'h01);
    unlock();
    op(0, 16'h0020, 8'h77, 1);
    exec_locked <= 1'b0;
    $display("test page locking done");
    // -------------------------------------------------------------
    // debug device erase clears everything, lock byte page included
    // -------------------------------------------------------------
    dbg_dev_erase <= 1'b1;
    tick(1);
    dbg_dev_erase <= 1'b0;
    #1;
    chk({cmd.erase, cmd.addr}, 17'h10000);
    for (i = 0; i < 400 && cmd.erase; i++)
    begin
      tick(1);
      #1;
    end
    guard(i < 400);
    chk({lock_byte, u_model.mem[14'h0500]}, 16'hffff);
    tick(1);
    // the captured lock only follows the erased array after the next reset
    do_reset();
    op(1, LOCK_ADDR, 8'h00, 2);
    op(1, LOCK_ADDR, 8'hfe, 1);
    op(1, LOCK_ADDR, 8'h00, 0);
    op(1, 16'h0100, 8'h11, 1);
    $display("test device erase done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
